// File: logic/tpf_consts.svh
// constants of the reset and initialisation block of the triple-port fifo
`ifndef TPF_CONSTS_SVH
`define TPF_CONSTS_SVH

// ***********************************************************************
// fifo geometry and flag offsets
// ***********************************************************************
`define TPF_DEPTH          7'h40
`define TPF_OFS_SEL_HH     5'h10
`define TPF_OFS_SEL_HL     5'h0C
`define TPF_OFS_SEL_LH     5'h08
`define TPF_OFS_SEL_LL     5'h04
`define TPF_OFS_RST        5'h04

// ***********************************************************************
// timing counts in port clock edges
// ***********************************************************************
`define TPF_FULL_EDGES     2'h2
`define TPF_RST_MIN_EDGES  3'h4

// ***********************************************************************
// reset values
// ***********************************************************************
`define TPF_PTR_RST        7'h00
`define TPF_EDGE_PREV_RST  1'b1
`define TPF_PIN_PREV_RST   1'b1
`define TPF_STATUS_RST     4'h0
`define TPF_ENABLE_RST     4'h0

// ***********************************************************************
// register offsets and event bit positions
// ***********************************************************************
`define TPF_REG_STATUS     4'h0
`define TPF_REG_CLEAR      4'h4
`define TPF_REG_ENABLE     4'h8
`define TPF_REG_FLAGS      4'hC
`define TPF_EV_RELEASE     0
`define TPF_EV_SHORT_RST   1
`define TPF_EV_EARLY_WR    2
`define TPF_EV_IGNORED     3

`endif

// File: logic/tpf_pkg.sv
// types of the reset and initialisation block of the triple-port fifo
`default_nettype none
package tpf_pkg;

  typedef logic [6:0] tpf_ptr_t;
  typedef logic [4:0] tpf_offset_t;
  typedef logic [3:0] tpf_event_t;

  typedef struct packed {
    logic full_n;
    logic empty_n;
    logic almost_empty_n;
    logic almost_full_n;
  } tpf_flags_t;

  typedef enum logic [2:0] {
    ST_POWERUP  = 3'b001,
    ST_IN_RESET = 3'b010,
    ST_RUN      = 3'b100
  } tpf_rst_state_t;

endpackage

`default_nettype wire

// File: logic/tpf_edge_det.sv
// rising edge detector for a port clock sampled by the system clock
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.svh"

module tpf_edge_det (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // sampled level and its rising edge
  input  wire logic sig_i,
  output var  logic rise_o
);

  logic prev;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prev <= `TPF_EDGE_PREV_RST;
    end else begin
      prev <= sig_i;
    end
  end

  assign rise_o = sig_i & ~prev;

endmodule // tpf_edge_det

`default_nettype wire

// File: logic/tpf_fifo_ptr.sv
// pointers and status flags of one fifo, with reset initialisation
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.svh"

module tpf_fifo_ptr import tpf_pkg::*; (
  // clock and resets
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  input  wire logic        dev_rst_i,
  // write side
  input  wire logic        wr_edge_i,
  input  wire logic        wr_en_i,
  // read side
  input  wire logic        rd_edge_i,
  input  wire logic        rd_en_i,
  // flag offset
  input  wire tpf_offset_t offset_i,
  // state
  output var  tpf_ptr_t    wr_ptr_o,
  output var  tpf_ptr_t    rd_ptr_o,
  output var  tpf_flags_t  flags_o,
  output var  logic        wr_ignored_o,
  output var  logic        rd_ignored_o
);

  logic     wr_ok;
  logic     rd_ok;
  logic     init;
  logic [1:0] rel_cnt;
  tpf_ptr_t occ;
  tpf_ptr_t occ_wr;
  tpf_ptr_t occ_rd;
  tpf_ptr_t ofs_ext;

  assign init    = srst_i | dev_rst_i;
  assign ofs_ext = {2'h0, offset_i};
  assign occ     = tpf_ptr_t'(wr_ptr_o - rd_ptr_o);
  // no transfer while reset is held
  assign wr_ok   = wr_edge_i & wr_en_i & flags_o.full_n & ~dev_rst_i;
  assign rd_ok   = rd_edge_i & rd_en_i & flags_o.empty_n & ~dev_rst_i;
  assign occ_wr  = tpf_ptr_t'(occ + {6'h00, wr_ok});
  assign occ_rd  = tpf_ptr_t'(occ - {6'h00, rd_ok});
  assign wr_ignored_o = wr_edge_i & wr_en_i & ~flags_o.full_n & ~dev_rst_i;
  assign rd_ignored_o = rd_edge_i & rd_en_i & ~flags_o.empty_n & ~dev_rst_i;

  // ***********************************************************************
  // pointers
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (init) begin
      wr_ptr_o <= `TPF_PTR_RST;
    end else if (wr_ok) begin
      wr_ptr_o <= tpf_ptr_t'(wr_ptr_o + 7'h01);
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      rd_ptr_o <= `TPF_PTR_RST;
    end else if (rd_ok) begin
      rd_ptr_o <= tpf_ptr_t'(rd_ptr_o + 7'h01);
    end
  end

  // ***********************************************************************
  // write side flags
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (init) begin
      rel_cnt <= 2'h0;
    end else if (wr_edge_i && rel_cnt != `TPF_FULL_EDGES) begin
      rel_cnt <= rel_cnt + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (init) begin
      flags_o.full_n        <= 1'b0;
      flags_o.almost_full_n <= 1'b1;
    end else if (wr_edge_i) begin
      // full stays low until the second write clock edge after release
      flags_o.full_n        <= (rel_cnt != 2'h0) && (occ_wr != `TPF_DEPTH);
      flags_o.almost_full_n <= tpf_ptr_t'(`TPF_DEPTH - occ_wr) > ofs_ext;
    end
  end

  // ***********************************************************************
  // read side flags
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (init) begin
      flags_o.empty_n        <= 1'b0;
      flags_o.almost_empty_n <= 1'b0;
    end else if (rd_edge_i) begin
      flags_o.empty_n        <= occ_rd != 7'h00;
      flags_o.almost_empty_n <= occ_rd > ofs_ext;
    end
  end

  // ***********************************************************************
  // assertions
  // ***********************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_PTR_INIT: assert property (dev_rst_i |=> wr_ptr_o == 7'h00 && rd_ptr_o == 7'h00)
    else $error("pointers not cleared by reset");
  AST_FLAGS_INIT: assert property (dev_rst_i |=> !flags_o.full_n && !flags_o.empty_n
                                   && !flags_o.almost_empty_n && flags_o.almost_full_n)
    else $error("flags not at reset state");
  AST_NO_RD_EMPTY: assert property (rd_edge_i && rd_en_i && !flags_o.empty_n
                                    |=> $stable(rd_ptr_o) || $past(dev_rst_i))
    else $error("read taken while empty");
  AST_NO_WR_FULL: assert property (wr_edge_i && wr_en_i && !flags_o.full_n
                                   |=> $stable(wr_ptr_o) || $past(dev_rst_i))
    else $error("write taken while full");
  AST_NO_XFER_RST: assert property (dev_rst_i ##1 dev_rst_i |-> occ == 7'h00
                                    && wr_ptr_o == 7'h00)
    else $error("transfer during reset");

endmodule // tpf_fifo_ptr

`default_nettype wire

// File: logic/tpf_reset_init.sv
// reset and initialisation logic of a triple-port fifo with two fifos
//
// Functional notes
// - reset pin may assert and release at any time, any clock phase
// - reset returns both pointers of both fifos to the first location
// - in reset full and empty flags low, almost-empty low, almost-full high
// - port A full flag goes high on second port A clock edge after release
// - port C full flag goes high on second port C clock edge after release
// - rising reset pin loads the flag offset from the two select inputs
// - selects high/high 16, high/low 12, low/high 8, low/low 4
// - empty flag low means nothing readable; reads then ignored
// - full flag low means no free location; writes then ignored
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.svh"

module tpf_reset_init import tpf_pkg::*; (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        srst_i,
  // device reset and offset selects
  input  wire logic        reset_n_i,
  input  wire logic        offset_select_0_i,
  input  wire logic        offset_select_1_i,
  // port clocks
  input  wire logic        port_a_clock_i,
  input  wire logic        port_b_clock_i,
  input  wire logic        port_c_clock_i,
  // port enables
  input  wire logic        port_a_chip_select_n_i,
  input  wire logic        port_a_write_select_i,
  input  wire logic        port_a_enable_i,
  input  wire logic        port_b_read_en_i,
  input  wire logic        port_c_write_en_i,
  // flags
  output var  logic        port_a_full_flag_n_o,
  output var  logic        port_c_full_flag_n_o,
  output var  logic        port_a_empty_flag_n_o,
  output var  logic        port_b_empty_flag_n_o,
  output var  logic        port_a_almost_empty_n_o,
  output var  logic        port_b_almost_empty_n_o,
  output var  logic        port_a_almost_full_n_o,
  output var  logic        port_c_almost_full_n_o,
  // fifo state
  output var  tpf_offset_t offset_o,
  output var  tpf_ptr_t    fifo1_wr_ptr_o,
  output var  tpf_ptr_t    fifo1_rd_ptr_o,
  output var  tpf_ptr_t    fifo2_wr_ptr_o,
  output var  tpf_ptr_t    fifo2_rd_ptr_o,
  // register port
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output var  logic [31:0] reg_rdata_o,
  output var  logic        irq_o
);

  // ***********************************************************************
  // reset pin and port clock edges
  // ***********************************************************************
  logic           dev_rst;
  logic           pin_prev;
  logic           rst_release;
  logic [2:0]     clk_lvl;
  logic [2:0]     edge_p;
  tpf_rst_state_t state;

  // reset pin acts as a level on every cycle, with no clock phase needed
  assign dev_rst       = ~reset_n_i;
  assign rst_release   = ~pin_prev & reset_n_i;
  assign clk_lvl       = {port_c_clock_i, port_b_clock_i, port_a_clock_i};

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pin_prev <= `TPF_PIN_PREV_RST;
    end else begin
      pin_prev <= reset_n_i;
    end
  end

  tpf_edge_det u_edge_a (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sig_i  (clk_lvl[0]),
    .rise_o (edge_p[0])
  );

  tpf_edge_det u_edge_b (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sig_i  (clk_lvl[1]),
    .rise_o (edge_p[1])
  );

  tpf_edge_det u_edge_c (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .sig_i  (clk_lvl[2]),
    .rise_o (edge_p[2])
  );

  // ***********************************************************************
  // reset sequence state
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_POWERUP;
    end else begin
      case (state)
        ST_POWERUP: begin
          if (dev_rst) begin
            state <= ST_IN_RESET;
          end
        end
        ST_IN_RESET: begin
          if (rst_release) begin
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (dev_rst) begin
            state <= ST_IN_RESET;
          end
        end
        default: begin
          state <= ST_POWERUP;
        end
      endcase
    end
  end

  // edges of each port clock seen while reset is held, saturating
  logic [2:0] rst_edges [3];
  logic       short_rst;

  for (genvar g = 0; g < 3; g++) begin : g_rst_edges
    always_ff @(posedge clk_i) begin
      if (srst_i || !dev_rst) begin
        rst_edges[g] <= 3'h0;
      end else if (edge_p[g] && rst_edges[g] != `TPF_RST_MIN_EDGES) begin
        rst_edges[g] <= rst_edges[g] + 3'h1;
      end
    end
  end

  // flags a release that came too early for one of the ports
  assign short_rst = rst_release && ((rst_edges[0] != `TPF_RST_MIN_EDGES)
                                    || (rst_edges[1] != `TPF_RST_MIN_EDGES)
                                    || (rst_edges[2] != `TPF_RST_MIN_EDGES));

  // ***********************************************************************
  // flag offset register
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      offset_o <= `TPF_OFS_RST;
    end else if (rst_release) begin
      case ({offset_select_1_i, offset_select_0_i})
        2'b11:   offset_o <= `TPF_OFS_SEL_HH;
        2'b10:   offset_o <= `TPF_OFS_SEL_HL;
        2'b01:   offset_o <= `TPF_OFS_SEL_LH;
        default: offset_o <= `TPF_OFS_SEL_LL;
      endcase
    end
  end

  // ***********************************************************************
  // the two fifos
  // ***********************************************************************
  logic       a_wr_en;
  logic       a_rd_en;
  logic [3:0] ignored;
  tpf_flags_t f1_flags;
  tpf_flags_t f2_flags;

  assign a_wr_en = ~port_a_chip_select_n_i & port_a_write_select_i & port_a_enable_i;
  assign a_rd_en = ~port_a_chip_select_n_i & ~port_a_write_select_i & port_a_enable_i;

  // fifo1: port A writes, port B reads
  tpf_fifo_ptr u_fifo1 (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .dev_rst_i    (dev_rst),
    .wr_edge_i    (edge_p[0]),
    .wr_en_i      (a_wr_en),
    .rd_edge_i    (edge_p[1]),
    .rd_en_i      (port_b_read_en_i),
    .offset_i     (offset_o),
    .wr_ptr_o     (fifo1_wr_ptr_o),
    .rd_ptr_o     (fifo1_rd_ptr_o),
    .flags_o      (f1_flags),
    .wr_ignored_o (ignored[0]),
    .rd_ignored_o (ignored[1])
  );

  // fifo2: port C writes, port A reads
  tpf_fifo_ptr u_fifo2 (
    .clk_i        (clk_i),
    .srst_i       (srst_i),
    .dev_rst_i    (dev_rst),
    .wr_edge_i    (edge_p[2]),
    .wr_en_i      (port_c_write_en_i),
    .rd_edge_i    (edge_p[0]),
    .rd_en_i      (a_rd_en),
    .offset_i     (offset_o),
    .wr_ptr_o     (fifo2_wr_ptr_o),
    .rd_ptr_o     (fifo2_rd_ptr_o),
    .flags_o      (f2_flags),
    .wr_ignored_o (ignored[2]),
    .rd_ignored_o (ignored[3])
  );

  assign port_a_full_flag_n_o    = f1_flags.full_n;
  assign port_a_almost_full_n_o  = f1_flags.almost_full_n;
  assign port_b_empty_flag_n_o   = f1_flags.empty_n;
  assign port_b_almost_empty_n_o = f1_flags.almost_empty_n;
  assign port_c_full_flag_n_o    = f2_flags.full_n;
  assign port_c_almost_full_n_o  = f2_flags.almost_full_n;
  assign port_a_empty_flag_n_o   = f2_flags.empty_n;
  assign port_a_almost_empty_n_o = f2_flags.almost_empty_n;

  // ***********************************************************************
  // events, status, enable and interrupt
  // ***********************************************************************
  tpf_event_t ev;
  tpf_event_t status;
  tpf_event_t enable;
  tpf_event_t clr_mask;
  tpf_event_t next_status;
  tpf_event_t next_enable;

  always_comb begin
    ev                    = 4'h0;
    ev[`TPF_EV_RELEASE]   = rst_release;
    ev[`TPF_EV_SHORT_RST] = short_rst;
    // write attempted before any device reset since the last system reset
    ev[`TPF_EV_EARLY_WR]  = (state == ST_POWERUP) && !dev_rst
                            && ((edge_p[0] && a_wr_en) || (edge_p[2] && port_c_write_en_i));
    ev[`TPF_EV_IGNORED]   = |ignored;
  end

  assign clr_mask    = (reg_wr_i && reg_addr_i == `TPF_REG_CLEAR) ? reg_wdata_i[3:0] : 4'h0;
  // a new event wins over a clear in the same cycle
  assign next_status = (status & ~clr_mask) | ev;
  assign next_enable = (reg_wr_i && reg_addr_i == `TPF_REG_ENABLE) ? reg_wdata_i[3:0] : enable;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      status <= `TPF_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      enable <= `TPF_ENABLE_RST;
    end else begin
      enable <= next_enable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_status & next_enable);
    end
  end

  // ***********************************************************************
  // register read
  // ***********************************************************************
  always_ff @(posedge clk_i) begin
    if (srst_i || !reg_rd_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else begin
      case (reg_addr_i)
        `TPF_REG_STATUS: reg_rdata_o <= {28'h000_0000, status};
        `TPF_REG_ENABLE: reg_rdata_o <= {28'h000_0000, enable};
        `TPF_REG_FLAGS:  reg_rdata_o <= {16'h0000, state, offset_o, f1_flags, f2_flags};
        default:         reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // ***********************************************************************
  // assertions
  // ***********************************************************************
  logic [1:0] a_rel;
  logic [1:0] c_rel;

  always_ff @(posedge clk_i) begin
    if (srst_i || dev_rst) begin
      a_rel <= 2'h0;
      c_rel <= 2'h0;
    end else begin
      if (edge_p[0] && a_rel != 2'h2) a_rel <= a_rel + 2'h1;
      if (edge_p[2] && c_rel != 2'h2) c_rel <= c_rel + 2'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  AST_FULL_A_HELD: assert property (!dev_rst && a_rel != 2'h2 |-> !port_a_full_flag_n_o)
    else $error("port A full flag rose too early");
  AST_FULL_A_SET: assert property (!dev_rst && a_rel == 2'h1 && edge_p[0] && !$past(dev_rst)
                                   ##1 !dev_rst |-> port_a_full_flag_n_o)
    else $error("port A full flag not set on second edge");
  AST_FULL_C_HELD: assert property (!dev_rst && c_rel != 2'h2 |-> !port_c_full_flag_n_o)
    else $error("port C full flag rose too early");
  AST_FULL_C_SET: assert property (!dev_rst && c_rel == 2'h1 && edge_p[2] && !$past(dev_rst)
                                   ##1 !dev_rst |-> port_c_full_flag_n_o)
    else $error("port C full flag not set on second edge");
  AST_OFS_LOAD: assert property ($rose(reset_n_i) |=> offset_o ==
      ($past({offset_select_1_i, offset_select_0_i}) == 2'b11 ? 5'h10 :
       $past({offset_select_1_i, offset_select_0_i}) == 2'b10 ? 5'h0C :
       $past({offset_select_1_i, offset_select_0_i}) == 2'b01 ? 5'h08 : 5'h04))
    else $error("offset not loaded from selects");
  AST_OFS_HOLD: assert property (!rst_release |=> $stable(offset_o))
    else $error("offset changed without reset release");
  AST_RST_ANY_TIME: assert property (!reset_n_i ##1 !reset_n_i |->
                                     !port_a_full_flag_n_o && !port_c_full_flag_n_o)
    else $error("reset not honoured");

  COV_RELEASE:   cover property (rst_release);
  COV_FULL_A_UP: cover property ($rose(port_a_full_flag_n_o));
  COV_SHORT_RST: cover property (short_rst);
  COV_IRQ:       cover property ($rose(irq_o));

endmodule // tpf_reset_init

`default_nettype wire

// File: tb/tpf_host_model.sv
// host side model: free-running port clocks
`timescale 1ns/10ps
`default_nettype none

module tpf_host_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic srst_i,
  // port clocks
  output var  logic port_a_clock_o,
  output var  logic port_b_clock_o,
  output var  logic port_c_clock_o
);
  logic [2:0] cnt_a;
  logic [2:0] cnt_b;
  logic [2:0] cnt_c;

  // three unrelated rates, so edges of the ports never line up for long
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cnt_a <= 3'h0;
      cnt_b <= 3'h0;
      cnt_c <= 3'h0;
      port_a_clock_o <= 1'b0;
      port_b_clock_o <= 1'b0;
      port_c_clock_o <= 1'b0;
    end else begin
      cnt_a <= (cnt_a == 3'h1) ? 3'h0 : cnt_a + 3'h1;
      cnt_b <= (cnt_b == 3'h2) ? 3'h0 : cnt_b + 3'h1;
      cnt_c <= (cnt_c == 3'h4) ? 3'h0 : cnt_c + 3'h1;
      if (cnt_a == 3'h1) port_a_clock_o <= !port_a_clock_o;
      if (cnt_b == 3'h2) port_b_clock_o <= !port_b_clock_o;
      if (cnt_c == 3'h4) port_c_clock_o <= !port_c_clock_o;
    end
  end
endmodule // tpf_host_model

`default_nettype wire

// File: tb/tpf_reset_init_tb.sv
// self-checking bench of the fifo reset and initialisation block
`timescale 1ns/10ps
`default_nettype none
`include "tpf_consts.svh"

module tpf_reset_init_tb import tpf_pkg::*;;
  logic clk_i, srst_i, reset_n_i, sel0, sel1, pa, pb, pc, pa_q, pc_q;
  logic cs_n, wsel, en_a, ren_b, wen_c, rwr, rrd, irq;
  logic fa, fc, ea, eb, aea, aeb, afa, afc;
  logic [3:0] raddr;
  logic [31:0] wdata, rdata, rd_v;
  tpf_offset_t ofs;
  tpf_ptr_t w1, r1, w2, r2;
  int fail_count, samples_checked, na, nc;
  logic [6:0] rows [4];

  tpf_host_model host (.clk_i(clk_i), .srst_i(srst_i), .port_a_clock_o(pa),
    .port_b_clock_o(pb), .port_c_clock_o(pc));

  tpf_reset_init dut (.clk_i(clk_i), .srst_i(srst_i), .reset_n_i(reset_n_i),
    .offset_select_0_i(sel0), .offset_select_1_i(sel1), .port_a_clock_i(pa),
    .port_b_clock_i(pb), .port_c_clock_i(pc), .port_a_chip_select_n_i(cs_n),
    .port_a_write_select_i(wsel), .port_a_enable_i(en_a), .port_b_read_en_i(ren_b),
    .port_c_write_en_i(wen_c), .port_a_full_flag_n_o(fa), .port_c_full_flag_n_o(fc),
    .port_a_empty_flag_n_o(ea), .port_b_empty_flag_n_o(eb),
    .port_a_almost_empty_n_o(aea), .port_b_almost_empty_n_o(aeb),
    .port_a_almost_full_n_o(afa), .port_c_almost_full_n_o(afc), .offset_o(ofs),
    .fifo1_wr_ptr_o(w1), .fifo1_rd_ptr_o(r1), .fifo2_wr_ptr_o(w2),
    .fifo2_rd_ptr_o(r2), .reg_addr_i(raddr), .reg_wdata_i(wdata), .reg_wr_i(rwr),
    .reg_rd_i(rrd), .reg_rdata_o(rdata), .irq_o(irq));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = !clk_i;
  end

  // port clock edges counted since release, as the design samples them
  always @(posedge clk_i) begin
    pa_q <= pa;
    pc_q <= pc;
    if (!reset_n_i) begin
      na <= 0;
      nc <= 0;
    end else begin
      if (pa && !pa_q && na < 3) na <= na + 1;
      if (pc && !pc_q && nc < 3) nc <= nc + 1;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    rwr <= 1'b1; raddr <= a; wdata <= d;
    @(posedge clk_i);
    rwr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk_i);
    rrd <= 1'b1; raddr <= a;
    @(posedge clk_i);
    rrd <= 1'b0;
    #1 rd_v = rdata;
  endtask

  // hold the device reset low, check the reset state, then release
  task automatic dev_reset(input int hold);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (hold) @(posedge clk_i);
    #1;
    check("flags", {fa, fc, ea, eb, aea, aeb, afa, afc}, 8'h03);
    check("ptrs", {w1, r1, w2, r2}, 28'h0);
    @(posedge clk_i);
    reset_n_i <= 1'b1;
  endtask

  // full flags stay low until the second port clock edge, then rise
  task automatic watch_full();
    repeat (40) begin
      @(negedge clk_i);
      if (na < 2) check("full_a", fa, 1'b0);
      if (na > 2) check("full_a", fa, 1'b1);
      if (nc < 2) check("full_c", fc, 1'b0);
      if (nc > 2) check("full_c", fc, 1'b1);
    end
    // hand back on a rising edge so the next stimulus is driven there
    @(posedge clk_i);
  endtask

  initial begin
    rows = '{{2'h3, `TPF_OFS_SEL_HH}, {2'h2, `TPF_OFS_SEL_HL},
             {2'h1, `TPF_OFS_SEL_LH}, {2'h0, `TPF_OFS_SEL_LL}};
    srst_i = 1'b1; reset_n_i = 1'b1; sel0 = 1'b0; sel1 = 1'b0;
    cs_n = 1'b1; wsel = 1'b0; en_a = 1'b0; ren_b = 1'b0; wen_c = 1'b0;
    rwr = 1'b0; rrd = 1'b0; raddr = 4'h0; wdata = 32'h0;
    repeat (20) @(posedge clk_i);
    srst_i <= 1'b0;
    // reads stay enabled throughout: fifos are empty so nothing may move
    cs_n <= 1'b0; en_a <= 1'b1; ren_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      sel1 <= rows[i][6];
      sel0 <= rows[i][5];
      dev_reset(40);
      watch_full();
      check("offset", ofs, rows[i][4:0]);
      check("rd_ptrs", {r1, r2}, 14'h0);
    end
    cs_n <= 1'b1; en_a <= 1'b0; ren_b <= 1'b0;
    reg_rd(`TPF_REG_STATUS);
    check("status", rd_v, 32'h9);
    check("irq_masked", irq, 1'b0);
    reg_wr(`TPF_REG_ENABLE, 32'h1);
    #1 check("irq_on", irq, 1'b1);
    reg_wr(`TPF_REG_CLEAR, 32'hF);
    #1 check("irq_off", irq, 1'b0);
    reg_rd(4'h2);
    check("unmapped", rd_v, 32'h0);
    // short reset at an arbitrary phase
    sel1 <= 1'b0;
    sel0 <= 1'b1;
    dev_reset(3);
    repeat (4) @(posedge clk_i);
    reg_rd(`TPF_REG_STATUS);
    check("status_short", rd_v, 32'h3);
    check("offset_short", ofs, `TPF_OFS_SEL_LH);
    cs_n <= 1'b0; wsel <= 1'b1; en_a <= 1'b1;
    repeat (40) @(posedge clk_i);
    #1 check("write_moved", w1 != 7'h00, 1'b1);
    cs_n <= 1'b1; en_a <= 1'b0;
    // mid-run system reset, then port C writes before any device reset
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    wen_c <= 1'b1;
    repeat (30) @(posedge clk_i);
    wen_c <= 1'b0;
    reg_rd(`TPF_REG_STATUS);
    check("status_early", rd_v, 32'hC);
    dev_reset(40);
    final_report();
  end

  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    final_report();
  end
endmodule // tpf_reset_init_tb

`default_nettype wire
